// [vidc_pkg.sv]
// Purpose: shared constants and types for the code-tracking supply checker
// Assumes: 40 MHz clock, Avalon-MM register slave with 32-bit data
// Notes: voltages are carried in half-millivolt units, 12 bits wide

package vidc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int WINDOW_US = 1500; // averaging window, 1.5 ms
  localparam int WINDOW_CYC = WINDOW_US * (CLK_HZ / 1_000_000);
  localparam int INTERVAL_MS = 100; // comparison interval, 100 ms
  localparam int INTERVAL_CYC = INTERVAL_MS * (CLK_HZ / 1000);
  localparam int SKEW_NS = 300; // settle time for line-to-line skew
  localparam int SKEW_CYC = (SKEW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] SKEW_CNT = 8'(SKEW_CYC);
  localparam int SAMPLE_SHIFT = 6;
  localparam int SAMPLES = 1 << SAMPLE_SHIFT;
  localparam logic [5:0] IDX_LAST = 6'h3F;

  // ****************************************************************
  // voltage scale and code tables
  // ****************************************************************
  localparam int HMV_W = 12;
  localparam int ACC_W = HMV_W + SAMPLE_SHIFT;
  localparam logic [12:0] CEIL_HMV = 13'h0C67; // 1.5875 V
  localparam logic [11:0] CORE_LSB_HMV = 12'h00E; // per adc count
  localparam logic [11:0] LEG_BASE = 12'hC80;
  localparam logic [11:0] LEG_STEP = 12'h019;
  localparam logic [6:0] LEG_OFF = 7'h3F;
  localparam logic [11:0] EXT_BASE = 12'hC80;
  localparam logic [11:0] EXT_STEP = 12'h00D;
  localparam logic [6:0] EXT_OFF = 7'h7F;
  localparam logic [11:0] NEW_BASE = 12'hC80;
  localparam logic [11:0] NEW_STEP = 12'h00C;
  localparam logic [6:0] NEW_OFF = 7'h00;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_UPPER = 6'h04;
  localparam logic [5:0] OFS_LOWER = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0C;
  localparam logic [5:0] OFS_MASK = 6'h10;
  localparam logic [5:0] OFS_AVG1 = 6'h14;
  localparam logic [5:0] OFS_AVG2 = 6'h18;
  localparam logic [5:0] OFS_TEMP = 6'h1C;
  localparam int AVG_OFF_BIT = 16;
  localparam int GPI_LSB = 4;
  localparam logic [11:0] OFS_RST = 12'h064;

  typedef enum logic [1:0] {
    VID_LEGACY,
    VID_EXTENDED,
    VID_NEWER7,
    VID_NEWER6
  } vidc_mode_e;

  typedef struct packed {
    logic temp_b_signed;
    logic temp_a_signed;
    logic check_en;
    vidc_mode_e mode;
  } vidc_ctrl_s;

  typedef struct packed {
    logic lo;
    logic hi;
  } vidc_err_s;

  localparam vidc_ctrl_s CTRL_RST = '{temp_b_signed: 1'b0,
    temp_a_signed: 1'b0, check_en: 1'b1, mode: VID_LEGACY};

endpackage

// [vidc_vid_lut.sv]
// Purpose: code to target voltage table with a registered read port
// Assumes: code is already filtered against skew
// Notes: one instance per processor

`timescale 1ns/1ps

module vidc_vid_lut (
  input wire logic clk,
  input wire logic reset,
  input wire vidc_pkg::vidc_mode_e mode,
  input wire logic [6:0] code,
  output logic [11:0] target,
  output logic off
);

  logic [11:0] next_target;
  logic next_off;
  logic [18:0] prod;

  // ****************************************************************
  // per-mode table, linear below the base, off codes flagged
  // ****************************************************************
  always_comb begin
    prod = '0;
    next_off = 1'b0;
    next_target = '0;
    case (mode)
      vidc_pkg::VID_LEGACY: begin
        prod = {13'h0000, code[5:0]} * {7'h00, vidc_pkg::LEG_STEP};
        next_off = ({1'b0, code[5:0]} == vidc_pkg::LEG_OFF);
        next_target = vidc_pkg::LEG_BASE - prod[11:0];
      end
      vidc_pkg::VID_EXTENDED: begin
        prod = {12'h000, code} * {7'h00, vidc_pkg::EXT_STEP};
        next_off = (code == vidc_pkg::EXT_OFF);
        next_target = vidc_pkg::EXT_BASE - prod[11:0];
      end
      vidc_pkg::VID_NEWER7: begin
        prod = {12'h000, code} * {7'h00, vidc_pkg::NEW_STEP};
        next_off = (code == vidc_pkg::NEW_OFF);
        next_target = vidc_pkg::NEW_BASE - prod[11:0];
      end
      default: begin
        // six-bit flavour of the newer table, top bit not decoded
        prod = {13'h0000, code[5:0]} * {7'h00, vidc_pkg::NEW_STEP};
        next_off = ({1'b0, code[5:0]} == vidc_pkg::NEW_OFF);
        next_target = vidc_pkg::NEW_BASE - prod[11:0];
      end
    endcase
    // off codes carry no meaningful target
    if (next_off) begin
      next_target = '0;
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (reset) begin
      target <= '0;
      off <= 1'b0;
    end else begin
      target <= next_target;
      off <= next_off;
    end
  end

endmodule

// [vidc_checker.sv]
// Purpose: tracks two processor supply readings against code-driven limits
// Assumes: all inputs synchronous to clk; interval longer than window
// Notes: window must hold at least 64 clock cycles

`timescale 1ns/1ps

module vidc_checker #(
  parameter int WINDOW_CYCLES = vidc_pkg::WINDOW_CYC,
  parameter int INTERVAL_CYCLES = vidc_pkg::INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [5:0] cpu1_voltage_code_inputs,
  input wire logic cpu1_seventh_code_bit,
  input wire logic [5:0] cpu2_voltage_code_inputs,
  input wire logic cpu2_seventh_code_bit,
  input wire logic [7:0] cpu1_core_supply_channel,
  input wire logic [7:0] cpu2_core_supply_channel,
  input wire logic [7:0] temp_capable_channel_a,
  input wire logic [7:0] temp_capable_channel_b,
  output logic [7:0] temp_a_reading,
  output logic [7:0] temp_b_reading,
  output logic interval_tick,
  output logic irq
);

  localparam logic [31:0] IVL_LAST = 32'(INTERVAL_CYCLES - 1);
  localparam logic [15:0] SAMP_LAST =
    16'(WINDOW_CYCLES / vidc_pkg::SAMPLES - 1);

  // ****************************************************************
  // declarations
  // ****************************************************************
  vidc_pkg::vidc_ctrl_s ctrl;
  logic [11:0] up_ofs;
  logic [11:0] lo_ofs;
  vidc_pkg::vidc_err_s [1:0] status;
  vidc_pkg::vidc_err_s [1:0] mask;
  vidc_pkg::vidc_err_s [1:0] set_vec;
  vidc_pkg::vidc_err_s [1:0] clr_vec;
  logic [1:0][6:0] raw_code;
  logic [1:0][6:0] prev_code;
  logic [1:0][6:0] good_code;
  logic [1:0][7:0] stab_cnt;
  logic [1:0][11:0] lut_target;
  logic [1:0] lut_off;
  logic [31:0] ivl_cnt;
  logic win_active;
  logic [15:0] sub_cnt;
  logic [5:0] samp_idx;
  logic [1:0][vidc_pkg::ACC_W-1:0] acc;
  logic [1:0] off_seen;
  logic cmp_go;
  logic [1:0][11:0] avg;
  logic [1:0][11:0] avg_q;
  logic [1:0] off_q;
  logic [1:0][12:0] upper;
  logic [1:0][12:0] lower;
  logic [1:0][12:0] reading;
  logic [1:0][7:0] chan;
  logic [1:0] over;
  logic [1:0] lower_ok;
  logic [1:0] gpi;
  logic [31:0] next_readdata;
  logic bus_req;
  logic wr_take;
  logic irq_src;
  logic [7:0] temp_a_flip;

  // ****************************************************************
  // code capture and skew filter
  // ****************************************************************
  // seventh bit joins the code except in legacy mode
  always_comb begin
    gpi = {cpu2_seventh_code_bit, cpu1_seventh_code_bit};
    if (ctrl.mode == vidc_pkg::VID_LEGACY) begin
      raw_code[0] = {1'b0, cpu1_voltage_code_inputs};
      raw_code[1] = {1'b0, cpu2_voltage_code_inputs};
    end else begin
      raw_code[0] = {cpu1_seventh_code_bit, cpu1_voltage_code_inputs};
      raw_code[1] = {cpu2_seventh_code_bit, cpu2_voltage_code_inputs};
    end
    chan[0] = cpu1_core_supply_channel;
    chan[1] = cpu2_core_supply_channel;
  end

  // a code is taken only after it holds still for the skew time
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_code <= '0;
      stab_cnt <= '0;
      good_code <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (raw_code[i] != prev_code[i]) begin
          prev_code[i] <= raw_code[i];
          stab_cnt[i] <= '0;
        end else if (stab_cnt[i] != vidc_pkg::SKEW_CNT) begin
          stab_cnt[i] <= stab_cnt[i] + 8'h01;
        end else begin
          good_code[i] <= prev_code[i];
        end
      end
    end
  end

  // table lookup per processor, steps every 5 us stay far above skew
  for (genvar g = 0; g < 2; g++) begin : g_lut
    vidc_vid_lut u_lut (
      .clk(clk),
      .reset(reset),
      .mode(ctrl.mode),
      .code(good_code[g]),
      .target(lut_target[g]),
      .off(lut_off[g])
    );
  end

  // ****************************************************************
  // interval timer and averaging window
  // ****************************************************************
  // free-running interval, tick marks each new comparison cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ivl_cnt <= '0;
      interval_tick <= 1'b0;
    end else begin
      interval_tick <= (ivl_cnt == IVL_LAST);
      if (ivl_cnt == IVL_LAST) begin
        ivl_cnt <= '0;
      end else begin
        ivl_cnt <= ivl_cnt + 32'h0000_0001;
      end
    end
  end

  // 64 evenly spaced samples; a power of two keeps the divide a shift
  always_ff @(posedge clk) begin
    if (reset) begin
      win_active <= 1'b0;
      sub_cnt <= '0;
      samp_idx <= '0;
      acc <= '0;
      off_seen <= '0;
      cmp_go <= 1'b0;
    end else begin
      cmp_go <= 1'b0;
      if (ivl_cnt == IVL_LAST) begin
        win_active <= 1'b1;
        sub_cnt <= '0;
        samp_idx <= '0;
        acc <= '0;
        off_seen <= '0;
      end else if (win_active) begin
        off_seen <= off_seen | lut_off;
        if (sub_cnt == SAMP_LAST) begin
          sub_cnt <= '0;
          samp_idx <= samp_idx + 6'h01;
          for (int i = 0; i < 2; i++) begin
            acc[i] <= acc[i] + vidc_pkg::ACC_W'(lut_target[i]);
          end
          if (samp_idx == vidc_pkg::IDX_LAST) begin
            win_active <= 1'b0;
            cmp_go <= 1'b1;
          end
        end else begin
          sub_cnt <= sub_cnt + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // limit comparison
  // ****************************************************************
  // readings scaled to the same half-millivolt unit as the targets
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      avg[i] = acc[i][vidc_pkg::ACC_W-1:vidc_pkg::SAMPLE_SHIFT];
      upper[i] = {1'b0, avg[i]} + {1'b0, up_ofs};
      lower[i] = {1'b0, avg[i]} - {1'b0, lo_ofs};
      lower_ok[i] = (avg[i] >= lo_ofs);
      over[i] = (upper[i] > vidc_pkg::CEIL_HMV);
      reading[i] = 13'({12'h000, chan[i]} * {8'h00, vidc_pkg::CORE_LSB_HMV});
      set_vec[i].hi = cmp_go && ctrl.check_en && !off_seen[i]
        && !over[i] && (reading[i] > upper[i]);
      set_vec[i].lo = cmp_go && ctrl.check_en && !off_seen[i]
        && lower_ok[i] && (reading[i] < lower[i]);
    end
  end

  // averaged targets kept for software after each comparison
  always_ff @(posedge clk) begin
    if (reset) begin
      avg_q <= '0;
      off_q <= '0;
    end else if (cmp_go) begin
      avg_q <= avg;
      off_q <= off_seen;
    end
  end

  // ****************************************************************
  // register slave
  // ****************************************************************
  assign bus_req = avs_read || avs_write;
  assign wr_take = avs_write && !avs_waitrequest;

  // one wait cycle, then a single-cycle acknowledge
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_readdata = '0;
    if (avs_address == vidc_pkg::OFS_CTRL) begin
      next_readdata = 32'(ctrl);
    end else if (avs_address == vidc_pkg::OFS_UPPER) begin
      next_readdata = 32'(up_ofs);
    end else if (avs_address == vidc_pkg::OFS_LOWER) begin
      next_readdata = 32'(lo_ofs);
    end else if (avs_address == vidc_pkg::OFS_STATUS) begin
      next_readdata = 32'(status);
      if (ctrl.mode == vidc_pkg::VID_LEGACY) begin
        next_readdata[vidc_pkg::GPI_LSB +: 2] = gpi;
      end
    end else if (avs_address == vidc_pkg::OFS_MASK) begin
      next_readdata = 32'(mask);
    end else if (avs_address == vidc_pkg::OFS_AVG1) begin
      next_readdata = 32'(avg_q[0]);
      next_readdata[vidc_pkg::AVG_OFF_BIT] = off_q[0];
    end else if (avs_address == vidc_pkg::OFS_AVG2) begin
      next_readdata = 32'(avg_q[1]);
      next_readdata[vidc_pkg::AVG_OFF_BIT] = off_q[1];
    end else if (avs_address == vidc_pkg::OFS_TEMP) begin
      next_readdata = {16'h0000, temp_b_reading, temp_a_reading};
    end
  end

  // read data captured in the wait cycle, held through the acknowledge
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // writable settings; offsets are software's to size for accuracy
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= vidc_pkg::CTRL_RST;
      up_ofs <= vidc_pkg::OFS_RST;
      lo_ofs <= vidc_pkg::OFS_RST;
      mask <= '0;
    end else if (wr_take) begin
      if (avs_address == vidc_pkg::OFS_CTRL) begin
        ctrl <= vidc_pkg::vidc_ctrl_s'(avs_writedata[4:0]);
      end else if (avs_address == vidc_pkg::OFS_UPPER) begin
        up_ofs <= avs_writedata[11:0];
      end else if (avs_address == vidc_pkg::OFS_LOWER) begin
        lo_ofs <= avs_writedata[11:0];
      end else if (avs_address == vidc_pkg::OFS_MASK) begin
        mask <= avs_writedata[3:0];
      end
    end
  end

  // ****************************************************************
  // status, interrupt and temperature outputs
  // ****************************************************************
  assign clr_vec = (wr_take && avs_address == vidc_pkg::OFS_STATUS) ?
    avs_writedata[3:0] : 4'h0;
  assign irq_src = |(status & mask);
  assign temp_a_flip = {~temp_capable_channel_a[7],
    temp_capable_channel_a[6:0]};

  // sticky error bits, a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~clr_vec) | set_vec;
      irq <= irq_src;
    end
  end

  // signed form flips the top bit only
  always_ff @(posedge clk) begin
    if (reset) begin
      temp_a_reading <= '0;
      temp_b_reading <= '0;
    end else begin
      temp_a_reading <= ctrl.temp_a_signed ? temp_a_flip
        : temp_capable_channel_a;
      temp_b_reading <= ctrl.temp_b_signed ?
        {~temp_capable_channel_b[7], temp_capable_channel_b[6:0]}
        : temp_capable_channel_b;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_skew_hold: assert property (@(posedge clk) disable iff (reset)
    (raw_code[0] != prev_code[0]) |=> ##1 $stable(good_code[0]))
    else $error("filtered code moved while input unsettled");

  a_off_skip: assert property (@(posedge clk) disable iff (reset)
    (cmp_go && off_seen[0]) |-> (set_vec[0] == 2'b00))
    else $error("error raised in a window with an off code");

  a_ceiling_skip: assert property (@(posedge clk) disable iff (reset)
    (cmp_go && over[1]) |-> !set_vec[1].hi)
    else $error("upper check ran above the ceiling");

  a_high_event: assert property (@(posedge clk) disable iff (reset)
    (cmp_go && ctrl.check_en && !off_seen[0] && !over[0]
      && reading[0] > upper[0]) |=> status[0].hi)
    else $error("high reading did not latch an error");

  a_low_limit: assert property (@(posedge clk) disable iff (reset)
    set_vec[0].lo |-> (reading[0] + {1'b0, lo_ofs} < {1'b0, avg[0]}))
    else $error("low error without reading under lower limit");

  a_cmp_after_win: assert property (@(posedge clk) disable iff (reset)
    $fell(win_active) && !interval_tick |-> cmp_go)
    else $error("window closed without a comparison");

  a_tick_window: assert property (@(posedge clk) disable iff (reset)
    interval_tick |-> win_active ##1 win_active[*7])
    else $error("window not open after interval tick");

  a_tick_pulse: assert property (@(posedge clk) disable iff (reset)
    interval_tick |=> !interval_tick)
    else $error("interval tick longer than one cycle");

  a_temp_sign: assert property (@(posedge clk) disable iff (reset)
    ctrl.temp_a_signed && $stable(ctrl.temp_a_signed)
      |-> temp_a_reading == $past(temp_a_flip))
    else $error("signed temperature not top-bit inverted");

  a_gpi_view: assert property (@(posedge clk) disable iff (reset)
    (avs_read && avs_waitrequest && avs_address == vidc_pkg::OFS_STATUS &&
      ctrl.mode == vidc_pkg::VID_LEGACY) |=> avs_readdata[5:4] == $past(gpi))
    else $error("general inputs missing from status view");

  a_wait_ack: assert property (@(posedge clk) disable iff (reset)
    (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus acknowledge not exactly one cycle");

  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    irq_src |=> irq)
    else $error("unmasked status did not raise interrupt");

endmodule

// [vidc_cpu_model.sv]
// Purpose: processor model driving one set of voltage code lines
// Assumes: one code step per STEP_CYCLES, lines skew on each step
// Notes: skew shows old|new for two cycles, as if lines rose early

`timescale 1ns/1ps

module vidc_cpu_model #(
  parameter int STEP_CYCLES = 200
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] want,
  input wire logic aux,
  output logic [5:0] code,
  output logic bit6
);
  // ****************************************************************
  // code stepping
  // ****************************************************************
  logic [5:0] cur;
  logic [5:0] prev;
  logic [7:0] gap;

  // one step at a time; reset jumps straight to the wanted code
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= want;
      prev <= want;
      gap <= 8'h00;
    end else if (gap != 8'h00) begin
      gap <= gap - 8'h01;
    end else if (cur != want) begin
      prev <= cur;
      cur <= (want > cur) ? cur + 6'h01 : cur - 6'h01;
      gap <= 8'(STEP_CYCLES - 1);
    end
  end

  // short skew mix is the worst case for the filter, e.g. 20 to 1F
  assign code = (gap > 8'(STEP_CYCLES - 3)) ? (cur | prev) : cur;
  assign bit6 = aux; // plain input level in legacy mode
endmodule

// [test_vidc_checker.sv]
// Purpose: self-checking bench for the code-tracking supply checker
// Assumes: short window and interval so the run stays brief
// Notes: two processor models drive the code lines

`timescale 1ns/1ps

module test_vidc_checker;
  // ****************************************************************
  // signals, models and design
  // ****************************************************************
  localparam int IVL = 2000;
  localparam logic [5:0] CT = vidc_pkg::OFS_CTRL;
  localparam logic [5:0] ST = vidc_pkg::OFS_STATUS;
  localparam logic [5:0] A1 = vidc_pkg::OFS_AVG1;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:0] want1 = 6'h10;
  logic [5:0] want2 = 6'h10;
  logic aux1 = 1'b0;
  logic aux2 = 1'b0;
  logic [5:0] code1, code2;
  logic b1, b2, tick, irq;
  logic [7:0] adc1 = 8'hC8;
  logic [7:0] adc2 = 8'hC8;
  logic [7:0] ta, tb;
  int n_errors = 0;
  int checks_done = 0;

  vidc_cpu_model cpu1 (.clk(clk), .reset(reset), .want(want1),
    .aux(aux1), .code(code1), .bit6(b1));
  vidc_cpu_model cpu2 (.clk(clk), .reset(reset), .want(want2),
    .aux(aux2), .code(code2), .bit6(b2));
  vidc_checker #(.WINDOW_CYCLES(640), .INTERVAL_CYCLES(IVL)) dut (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cpu1_voltage_code_inputs(code1), .cpu1_seventh_code_bit(b1),
    .cpu2_voltage_code_inputs(code2), .cpu2_seventh_code_bit(b2),
    .cpu1_core_supply_channel(adc1), .cpu2_core_supply_channel(adc2),
    .temp_capable_channel_a(8'h21), .temp_capable_channel_b(8'h90),
    .temp_a_reading(ta), .temp_b_reading(tb),
    .interval_tick(tick), .irq(irq));

  // free-running 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  task automatic wait_ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      while (tick !== 1'b1) @(posedge clk);
    end
  endtask

  task automatic rst();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  // scenarios in order; the off and ceiling and the ramp scenarios reset the design first
  initial begin
    int n;
    rst();
    rd(CT, 32'h04);
    rd(vidc_pkg::OFS_UPPER, 32'h64);
    rd(vidc_pkg::OFS_LOWER, 32'h64);
    rd(vidc_pkg::OFS_MASK, 32'h0);
    wr(6'h20, 32'h1F);
    rd(6'h20, 32'h0);
    rd(CT, 32'h04);
    check({24'h0, ta}, 32'h21);
    wr(CT, 32'h1C);
    rd(vidc_pkg::OFS_TEMP, 32'h10A1);
    check({24'h0, tb}, 32'h10);
    wr(CT, 32'h04);
    $display("test registers done");
    aux1 <= 1'b1;
    rd(ST, 32'h10, 32'h30);
    aux1 <= 1'b0;
    aux2 <= 1'b1;
    rd(ST, 32'h20, 32'h30);
    wr(CT, 32'h05);
    rd(ST, 32'h00, 32'h30);
    wr(CT, 32'h04);
    aux2 <= 1'b0;
    $display("test general inputs done");
    // high error on cpu1, low error on cpu2 around target 0xAF0
    adc1 <= 8'hDC;
    adc2 <= 8'hBE;
    wait_ticks(1);
    wr(ST, 32'h0F);
    wait_ticks(1);
    rd(ST, 32'h09);
    rd(A1, 32'hAF0);
    check({31'h0, irq}, 32'h0);
    wr(vidc_pkg::OFS_MASK, 32'h01);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(ST, 32'h01);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd(ST, 32'h08);
    // start counting right after a tick so one full interval is measured
    wait_ticks(1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1);
    check(n, IVL);
    $display("test limits done");
    // off code on cpu1, ceiling case on cpu2
    want1 <= 6'h3F;
    want2 <= 6'h00;
    adc1 <= 8'h32;
    adc2 <= 8'hFF;
    rst();
    wait_ticks(2);
    rd(ST, 32'h00, 32'h0F);
    rd(A1, 32'h10000, 32'h10000);
    adc2 <= 8'h64;
    wait_ticks(1);
    rd(ST, 32'h08, 32'h0F);
    $display("test off and ceiling done");
    // twenty-step ramp, then a step whose skew mimics an off code
    want1 <= 6'h0C;
    want2 <= 6'h10;
    adc1 <= 8'hAD;
    adc2 <= 8'hC8;
    rst();
    want1 <= 6'h20;
    wait_ticks(3);
    want1 <= 6'h1F;
    wait_ticks(1);
    rd(A1, 32'h0, 32'h10000);
    wr(ST, 32'h0F);
    wait_ticks(1);
    rd(ST, 32'h00, 32'h0F);
    rd(A1, 32'h979);
    $display("test ramp done");
    // other code modes on code 0x1F; two ticks give one whole window
    for (int i = 1; i < 4; i++) begin
      wr(CT, 32'h04 | i);
      wait_ticks(2);
      rd(A1, (i == 1) ? 32'hAED : 32'hB0C);
    end
    $display("test modes done");
    wrap_up();
  end

  // cuts a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
